/* File: hdl/prioritized_interrupt_latch_unit.sv */
// latches, gates and prioritises interrupt requests for the core
`timescale 1ns/1ns
`default_nettype none

module prioritized_interrupt_latch_unit
  import irq_latch_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  input  wire logic        i_software_trap_request,
  input  wire logic        i_bad_opcode_request,
  input  wire logic        i_address_trap_request,
  input  wire logic        i_watchdog_request,
  input  wire logic        i_external_request_0,
  input  wire logic        i_ext0_pin_function_enable,
  input  wire logic        i_external_request_1,
  input  wire logic        i_time_base_request,
  input  wire logic        i_external_request_2,
  input  wire logic        i_tone_counter_request,
  input  wire logic        i_serial_receive_request,
  input  wire logic        i_sync_serial_request,
  input  wire logic        i_serial_transmit_request,
  input  wire logic        i_timer4_request,
  input  wire logic        i_timer6_request,
  input  wire logic        i_converter_done_request,
  input  wire logic        i_external_request_3,
  input  wire logic        i_timer3_request,
  input  wire logic        i_external_request_5,
  input  wire logic        i_timer5_request,
  input  wire logic        i_accept,
  input  wire logic        i_return_from_handler,
  input  wire logic        i_reset_fetch,
  output logic             o_irq_request,
  output logic      [15:0] o_irq_vector,
  output logic      [3:0]  o_irq_level,
  output logic             o_master_irq_enable
);

  // external pins come from outside the clock domain
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [15:0] pending_latch;
  logic [15:0] source_enable;
  logic        master_irq_enable;
  logic        saved_master;
  logic [2:0]  shared_level_select;
  accept_state_e state;
  irq_offer_s    offer;

  wire logic [4:0] pins_raw = {i_external_request_5, i_external_request_3,
                               i_external_request_2, i_external_request_1,
                               i_external_request_0};
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= pins_raw;
      pin_sync <= pin_meta;
    end
  end

  wire logic level9_selector  = shared_level_select[2];
  wire logic level14_selector = shared_level_select[1];
  wire logic level15_selector = shared_level_select[0];

  wire logic req9  = level9_selector  ? i_sync_serial_request
                                      : i_serial_receive_request;
  wire logic req14 = level14_selector ? i_timer3_request : pin_sync[3];
  wire logic req15 = level15_selector ? i_timer5_request : pin_sync[4];

  wire logic [15:0] set_vec = {req15, req14, i_converter_done_request,
                               i_timer6_request, i_timer4_request,
                               i_serial_transmit_request, req9,
                               i_tone_counter_request, pin_sync[2],
                               i_time_base_request, pin_sync[1],
                               pin_sync[0], i_watchdog_request,
                               i_address_trap_request, 2'b00};

  wire logic [15:0] gate_vec;
  assign gate_vec[3:0] = 4'b1100;
  assign gate_vec[FIRST_MASKABLE] = master_irq_enable
                                    & source_enable[FIRST_MASKABLE]
                                    & i_ext0_pin_function_enable;
  assign gate_vec[15:5] = {11{master_irq_enable}} & source_enable[15:5];
  wire logic [15:0] asking = pending_latch & gate_vec;

  function automatic logic [3:0] lowest_bit(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 2; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [15:0] vector_of(input logic [3:0] b);
    logic [15:0] v;
    v = VEC_TRAP - {11'h000, b - 4'h2, 1'b0};
    return v;
  endfunction

  wire logic        sw_now     = i_software_trap_request
                                 | i_bad_opcode_request;
  wire logic [3:0]  win_bit    = lowest_bit(asking);
  wire logic        any_ask    = |asking;
  wire logic [15:0] next_vec   = i_reset_fetch ? VEC_RESET :
                                 sw_now ? VEC_SOFT : vector_of(win_bit);
  // priority figure: bit n maps to n+1, non-maskables share 2
  wire logic [3:0]  next_level = i_reset_fetch ? 4'h1 :
                                 (sw_now || win_bit < 4'h4) ? 4'h2 :
                                 win_bit + 4'h1;
  wire logic        next_valid = i_reset_fetch | sw_now | any_ask;
  // clear winner on accept
  // judge by what was offered, not by this cycle's inputs
  wire logic        take_latch = i_accept && offer.valid
                                 && offer.vector != VEC_RESET
                                 && offer.vector != VEC_SOFT;
  wire logic [15:0] accept_clr = take_latch ? (16'h0001 << offer.level - 4'h1)
                                            : 16'h0000;
  // bit index is level-1 only for maskables; fix non-maskables below
  wire logic [15:0] nm_clr = (take_latch && offer.vector == VEC_TRAP)
                             ? 16'h0004 : (take_latch &&
                             offer.vector == VEC_WATCHDOG) ? 16'h0008 : 16'h0;
  wire logic [15:0] clr_mask = (offer.level == 4'h2) ? nm_clr : accept_clr;

  wire logic wr_pl = i_sfr_wr && i_sfr_addr == ADDR_PENDING_LOW;
  wire logic wr_ph = i_sfr_wr && i_sfr_addr == ADDR_PENDING_HIGH;
  wire logic wr_el = i_sfr_wr && i_sfr_addr == ADDR_ENABLE_LOW;
  wire logic wr_eh = i_sfr_wr && i_sfr_addr == ADDR_ENABLE_HIGH;
  wire logic wr_sl = i_sfr_wr && i_sfr_addr == ADDR_LEVEL_SELECT;

  wire logic [15:0] sw_clr = {wr_ph ? ~i_sfr_wdata : 8'h00,
                              wr_pl ? ~i_sfr_wdata : 8'h00};
  // set wins over any clear in the same cycle
  wire logic [15:0] next_pending = ((pending_latch & ~sw_clr & ~clr_mask)
                                    | set_vec) & 16'hfffc;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pending_latch <= PENDING_RESET;
    end else begin
      pending_latch <= next_pending;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      master_irq_enable   <= 1'b0;
      saved_master        <= 1'b0;
      source_enable       <= ENABLE_RESET;
      shared_level_select <= SELECT_RESET;
    end else begin
      if (i_accept && offer.valid) begin
        saved_master      <= master_irq_enable;
        master_irq_enable <= 1'b0;
      end else if (i_return_from_handler) begin
        master_irq_enable <= saved_master;
      end else if (wr_el) begin
        master_irq_enable <= i_sfr_wdata[MASTER_BIT];
      end
      if (wr_el) begin
        source_enable[7:4] <= i_sfr_wdata[7:4];
      end
      if (wr_eh) begin
        source_enable[15:8] <= i_sfr_wdata;
      end
      if (wr_sl) begin
        shared_level_select <= {i_sfr_wdata[SEL9_BIT],
                                i_sfr_wdata[SEL14_BIT],
                                i_sfr_wdata[SEL15_BIT]};
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state <= ST_IDLE;
      offer <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (next_valid) begin
            state <= ST_OFFER;
          end
        end
        ST_OFFER: begin
          if (i_accept) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      offer.valid  <= next_valid && !(i_accept && offer.valid);
      offer.vector <= next_vec;
      offer.level  <= next_level;
    end
  end

  assign o_sfr_rdata =
    (i_sfr_addr == ADDR_PENDING_LOW)  ? pending_latch[7:0] :
    (i_sfr_addr == ADDR_PENDING_HIGH) ? pending_latch[15:8] :
    (i_sfr_addr == ADDR_ENABLE_LOW)   ? {source_enable[7:4], 3'h0,
                                         master_irq_enable} :
    (i_sfr_addr == ADDR_ENABLE_HIGH)  ? source_enable[15:8] :
    (i_sfr_addr == ADDR_LEVEL_SELECT) ? {1'b0, shared_level_select[2], 4'h0,
                                         shared_level_select[1:0]} : 8'h00;

  assign o_irq_request       = offer.valid;
  assign o_irq_vector        = offer.vector;
  assign o_irq_level         = offer.level;
  assign o_master_irq_enable = master_irq_enable;

  a_accept_clears: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    take_latch && offer.level > 4'h4 && !set_vec[offer.level - 4'h1]
    |=> !pending_latch[$past(offer.level) - 4'h1])
    else $error("accepted latch not cleared");
  a_write_no_set: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    wr_pl && set_vec[7:0] == 8'h00 |=> (pending_latch[7:0] &
    ~$past(pending_latch[7:0])) == 8'h00)
    else $error("software write set a latch");
  a_write_zero_clr: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    wr_ph && !i_sfr_wdata[0] && !set_vec[8] |=> !pending_latch[8])
    else $error("write of zero did not clear");
  a_request_sets: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    set_vec[6] |=> pending_latch[6])
    else $error("request did not set latch");
  a_master_gate: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !master_irq_enable |-> asking[15:4] == 12'h000)
    else $error("maskable asked with master off");
  a_accept_master: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    i_accept && offer.valid |=> !master_irq_enable)
    else $error("master not cleared on accept");
  a_trap_vector: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    asking[2] && !i_reset_fetch && !sw_now && !(i_accept && offer.valid)
    |=> offer.valid
    && offer.vector == VEC_TRAP)
    else $error("trap vector wrong");
  a_level_vector: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    win_bit == 4'hf && asking == 16'h8000 && !i_reset_fetch && !sw_now
    // priority 16 wraps to 0 in the four-bit level
    |=> offer.vector == 16'hffe0 && offer.level == 4'h0)
    else $error("level 15 vector wrong");
  a_unselected: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    level14_selector && !i_timer3_request && !pending_latch[14]
    |=> !pending_latch[14])
    else $error("unselected source latched");
  a_reset_clear: assert property (@(posedge i_sys_clk)
    i_srst |=> pending_latch == 16'h0000)
    else $error("reset left a latch");
  c_accept: cover property (@(posedge i_sys_clk) i_accept && offer.valid);
  c_nested: cover property (@(posedge i_sys_clk)
    i_return_from_handler && saved_master);
  c_clear_write: cover property (@(posedge i_sys_clk) wr_pl && |pending_latch);

endmodule : prioritized_interrupt_latch_unit
`default_nettype wire

/* File: common/irq_latch_pkg.sv */
// constants and types for the prioritized interrupt latch unit
package irq_latch_pkg;
  localparam logic [7:0]  ADDR_ENABLE_LOW   = 8'h3a;
  localparam logic [7:0]  ADDR_ENABLE_HIGH  = 8'h3b;
  localparam logic [7:0]  ADDR_PENDING_LOW  = 8'h3c;
  localparam logic [7:0]  ADDR_PENDING_HIGH = 8'h3d;
  localparam logic [7:0]  ADDR_LEVEL_SELECT = 8'h3e;
  localparam logic [15:0] PENDING_RESET     = 16'h0000;
  localparam logic [15:0] ENABLE_RESET      = 16'h0000;
  localparam logic [2:0]  SELECT_RESET      = 3'h0;
  localparam logic [15:0] VEC_RESET         = 16'hfffe;
  localparam logic [15:0] VEC_SOFT          = 16'hfffc;
  localparam logic [15:0] VEC_TRAP          = 16'hfffa;
  localparam logic [15:0] VEC_WATCHDOG      = 16'hfff8;
  localparam logic [15:0] VEC_LEVEL4        = 16'hfff6;
  localparam int          MASTER_BIT        = 0;
  localparam int          TRAP_BIT          = 2;
  localparam int          WATCHDOG_BIT      = 3;
  localparam int          FIRST_MASKABLE    = 4;
  localparam int          SEL9_BIT          = 6;
  localparam int          SEL14_BIT         = 1;
  localparam int          SEL15_BIT         = 0;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_OFFER  = 2'b01
  } accept_state_e;

  typedef struct packed {
    logic        valid;
    logic [15:0] vector;
    logic [3:0]  level;
  } irq_offer_s;
endpackage : irq_latch_pkg

/* File: test/core_accept_model.sv */
// behavioural core that takes interrupt offers
`timescale 1ns/1ns
`default_nettype none
module core_accept_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_ready,
  input  wire logic [3:0]  i_delay,
  input  wire logic        i_irq_request,
  input  wire logic [15:0] i_irq_vector,
  input  wire logic [3:0]  i_irq_level,
  output logic             o_accept,
  output logic      [15:0] o_vector,
  output logic      [3:0]  o_level,
  output int               o_count
);
  int wait_n = 0;
  initial begin
    o_accept = 1'b0;
    o_vector = 16'h0000;
    o_level = 4'h0;
    o_count = 0;
  end
  // one accept per offer, never twice
  always @(posedge i_sys_clk) begin
    o_accept <= 1'b0;
    if (i_ready && i_irq_request && !o_accept) begin
      if (wait_n < int'(i_delay)) begin
        wait_n <= wait_n + 1;
      end else begin
        wait_n <= 0;
        o_accept <= 1'b1;
        o_vector <= i_irq_vector;
        o_level <= i_irq_level;
        o_count <= o_count + 1;
      end
    end
  end
endmodule // core_accept_model
`default_nettype wire

/* File: test/prioritized_interrupt_latch_unit_tb.sv */
// self-checking bench for the interrupt latch unit
`timescale 1ns/1ns
`default_nettype none
module prioritized_interrupt_latch_unit_tb;
  import irq_latch_pkg::*;
  logic        clk = 0, srst = 1, wr = 0, pin0 = 0, ret = 0, rf = 0, rdy = 0;
  logic [7:0]  addr = 0, wdata = 0, rdata;
  logic [18:0] src = 0;
  logic [3:0]  dly = 0, lvl, c_lvl;
  logic        req, acc, master;
  logic [15:0] vec, c_vec, p;
  logic [2:0]  sel = 0;
  int          c_cnt, n_errors = 0, tests_run = 0, cycles = 0;
  int          seed = 32'h7408;
  always #4 clk = ~clk;
  prioritized_interrupt_latch_unit prioritized_interrupt_latch_unit_i (
    .i_sys_clk(clk), .i_srst(srst), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_software_trap_request(src[0]), .i_bad_opcode_request(src[1]),
    .i_address_trap_request(src[2]), .i_watchdog_request(src[3]),
    .i_external_request_0(src[4]), .i_ext0_pin_function_enable(pin0),
    .i_external_request_1(src[5]), .i_time_base_request(src[6]),
    .i_external_request_2(src[7]), .i_tone_counter_request(src[8]),
    .i_serial_receive_request(src[9]), .i_sync_serial_request(src[16]),
    .i_serial_transmit_request(src[10]), .i_timer4_request(src[11]),
    .i_timer6_request(src[12]), .i_converter_done_request(src[13]),
    .i_external_request_3(src[14]), .i_timer3_request(src[17]),
    .i_external_request_5(src[15]), .i_timer5_request(src[18]),
    .i_accept(acc), .i_return_from_handler(ret), .i_reset_fetch(rf),
    .o_irq_request(req), .o_irq_vector(vec), .o_irq_level(lvl),
    .o_master_irq_enable(master));
  core_accept_model core_accept_model_i (
    .i_sys_clk(clk), .i_ready(rdy), .i_delay(dly), .i_irq_request(req),
    .i_irq_vector(vec), .i_irq_level(lvl), .o_accept(acc),
    .o_vector(c_vec), .o_level(c_lvl), .o_count(c_cnt));
  function automatic logic [15:0] vec_of(int b);
    return 16'hfffe - 16'(2 * b);
  endfunction
  function automatic logic [3:0] lvl_of(int b);
    return (b < 4) ? 4'h2 : 4'(b + 1);
  endfunction
  function automatic logic sel_of(int b);
    return b == 9 ? sel[2] : b == 14 ? sel[1] : b == 15 ? sel[0] : 1'b0;
  endfunction
  // alternate source sits on the upper request lines
  function automatic int src_of(int b, logic alt);
    return !alt ? b : b == 9 ? 16 : b == 14 ? 17 : 18;
  endfunction
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic pend;
    rd_reg(ADDR_PENDING_LOW, p[7:0]);
    rd_reg(ADDR_PENDING_HIGH, p[15:8]);
  endtask
  task automatic set_en(logic [15:0] e);
    wr_reg(ADDR_ENABLE_LOW, e[7:0] & 8'hfe);
    wr_reg(ADDR_ENABLE_HIGH, e[15:8]);
    if (e[0]) wr_reg(ADDR_ENABLE_LOW, e[7:0]);
  endtask
  task automatic pulse(int i);
    @(posedge clk);
    src[i] <= 1'b1;
    @(posedge clk);
    src[i] <= 1'b0;
    tick(4);
  endtask
  task automatic give_back;
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    tick(2);
  endtask
  task automatic take(logic [15:0] ev, logic [3:0] el);
    int n0;
    n0 = c_cnt;
    @(posedge clk);
    dly <= 4'($random(seed) & 3);
    rdy <= 1'b1;
    for (int k = 0; k < 30 && c_cnt == n0; k++) @(posedge clk);
    rdy <= 1'b0;
    check(c_vec, ev);
    check(c_lvl, el);
    tick(2);
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bound well above the longest expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    logic s;
    int a, c;
    tick(3);
    srst <= 1'b0;
    for (int r = 8'h3a; r < 8'h40; r++) begin
      rd_reg(8'(r), p[7:0]);
      check(p[7:0], 8'h00);
    end
    $display("test reset done");
    // trap and timeout assumed routed to interrupt
    for (int b = 2; b < 16; b++) begin
      sel = 3'($random(seed));
      s = sel_of(b);
      wr_reg(ADDR_LEVEL_SELECT, {1'b0, sel[2], 4'h0, sel[1:0]});
      rd_reg(ADDR_LEVEL_SELECT, p[7:0]);
      check(p[7:0], {1'b0, sel[2], 4'h0, sel[1:0]});
      if (b == 9 || b > 13) begin
        pulse(src_of(b, !s));
        pend();
        check(p, 16'h0000);
      end
      pulse(src_of(b, s));
      pend();
      check(p, 16'h1 << b);
      if (b > 3) begin
        check(req, 1'b0);
        set_en(16'h1 << b);
        tick(3);
        check(req, 1'b0);
        set_en((16'h1 << b) | 16'h1);
        tick(3);
        check(req, b != 4);
        @(posedge clk) pin0 <= 1'b1;
      end
      tick(3);
      check(req, 1'b1);
      check(vec, vec_of(b));
      take(vec_of(b), lvl_of(b));
      pend();
      check(p, 16'h0000);
      check(master, 1'b0);
      give_back();
      check(master, b > 3);
      // drop master first, as software does
      set_en(16'h0000);
      @(posedge clk) pin0 <= 1'b0;
    end
    $display("test sources done");
    pin0 <= 1'b1;
    for (int k = 0; k < 12; k++) begin
      a = 4 + {$random(seed)} % 12;
      c = 4 + (a - 3 + {$random(seed)} % 11) % 12;
      pulse(src_of(a, sel_of(a)));
      pulse(src_of(c, sel_of(c)));
      set_en((16'h1 << a) | (16'h1 << c));
      set_en((16'h1 << a) | (16'h1 << c) | 16'h1);
      tick(3);
      check(vec, vec_of(a < c ? a : c));
      take(vec_of(a < c ? a : c), lvl_of(a < c ? a : c));
      check(req, 1'b0);
      give_back();
      take(vec_of(a < c ? c : a), lvl_of(a < c ? c : a));
      give_back();
      set_en(16'h0000);
    end
    $display("test priority done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) src[i] <= 1'b1;
      tick(3);
      check(vec, VEC_SOFT);
      @(posedge clk) rf <= 1'b1;
      tick(3);
      check(vec, VEC_RESET);
      check(lvl, 4'h1);
      @(posedge clk) rf <= 1'b0;
      tick(3);
      take(VEC_SOFT, 4'h2);
      @(posedge clk) src[i] <= 1'b0;
      give_back();
      check(req, 1'b0);
    end
    $display("test non-latched done");
    pulse(5);
    pulse(12);
    wr_reg(ADDR_PENDING_LOW, 8'hff);
    wr_reg(ADDR_PENDING_HIGH, 8'hff);
    pend();
    check(p, 16'h1020);
    wr_reg(ADDR_PENDING_LOW, 8'hdf); // zero bits clear, one bits keep
    pend();
    check(p, 16'h1000);
    wr_reg(ADDR_PENDING_HIGH, 8'h00);
    pend();
    check(p, 16'h0000);
    pulse(6);
    @(posedge clk) srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    pend();
    check(p, 16'h0000);
    $display("test register writes done");
    conclude();
  end
endmodule // prioritized_interrupt_latch_unit_tb
`default_nettype wire
